// file: bench/accel_config_status_regs_properties.sv
// concurrent checks on the sensor register bank ports
module accel_regs_checker #(
   parameter int LATCH_TICK_CYC = accel_regs_pkg::LATCH_TICK_CYC
) (
   // clock, reset and bus
   input wire logic        core_clk_i, reset_n_i, write_i, waitrequest_o,
   input wire logic [7:0]  address_i,
   input wire logic [31:0] writedata_i,
   input wire logic [3:0]  byteenable_i,
   // settings
   input wire logic [3:0]  range_o, doze_len_o,
   input wire logic [4:0]  filter_width_code_o, event_enable_b_o,
   input wire logic [2:0]  power_mode_o,
   input wire logic        top_output_rate_o, power_variant_o,
   input wire logic        restart_busy_o,
   input wire logic [7:0]  event_enable_a_o
);
   timeunit 1ns;
   timeprecision 1ps;
   default clocking cb @(posedge core_clk_i); endclocking
   default disable iff (!reset_n_i);
   wire logic       cw = write_i && !waitrequest_o && byteenable_i[0];
   wire logic [5:0] ix = address_i[7:2];
   wire logic [7:0] wd = writedata_i[7:0];

   chk_range_rst: assert property (
      $rose(reset_n_i) |-> range_o == 4'h3 && filter_width_code_o == 5'h0f)
      else $error("bad scale or filter reset value");
   chk_enable_rst: assert property (
      $rose(reset_n_i) |-> event_enable_a_o == 8'h00 && !event_enable_b_o)
      else $error("enables not cleared at reset");
   chk_top_rate: assert property (
      top_output_rate_o == ($past(filter_width_code_o) >= 5'h0f))
      else $error("top rate flag wrong");
   chk_range_wr: assert property (
      cw && ix == 6'h0f |=> range_o == 4'($past(wd)))
      else $error("scale write not applied");
   chk_power_wr: assert property (
      cw && ix == 6'h11 |=> power_mode_o == 3'($past(wd) >> 5)
         && doze_len_o == 4'($past(wd) >> 1))
      else $error("power mode or doze write not applied");
   chk_variant_wr: assert property (
      cw && ix == 6'h12 |=> power_variant_o == 1'($past(wd) >> 6))
      else $error("variant write not applied");
   chk_enable_wr: assert property (
      cw && ix == 6'h16 |=> event_enable_a_o == ($past(wd) & 8'hf7))
      else $error("enable write wrong");
   chk_restart_go: assert property (
      cw && ix == 6'h14 && wd == 8'hb6 |=> restart_busy_o [*8])
      else $error("restart not started");
   chk_restart_skip: assert property (
      cw && ix == 6'h14 && wd != 8'hb6 && !restart_busy_o |=> !restart_busy_o)
      else $error("restart started by wrong code");
   chk_restart_end: assert property (
      $fell(restart_busy_o) |-> ##[0:1] range_o == 4'h3
         && event_enable_a_o == 8'h00)
      else $error("settings not restored after restart");
endmodule : accel_regs_checker

bind accel_config_status_regs accel_regs_checker #(
   .LATCH_TICK_CYC(LATCH_TICK_CYC)) chk_u (.*);

// file: bench/accel_config_status_regs_test.sv
// self-checking bench of the sensor register bank
module accel_config_status_regs_test;
   timeunit 1ns;
   timeprecision 1ps;
   logic        core_clk_i, reset_n_i, read_i, write_i, waitrequest_o;
   logic [7:0]  address_i, event_enable_a_o, q;
   logic [31:0] writedata_i, readdata_o;
   logic [3:0]  byteenable_i, range_o, doze_len_o;
   logic        level_pos_i, pose_block_i, high_trig_i, high_sign_i;
   logic [2:0]  pose_i, high_axis_i, power_mode_o;
   logic [41:0] acc_filt_i, acc_raw_i;
   logic [4:0]  filter_width_code_o, event_enable_b_o;
   logic        top_output_rate_o, power_variant_o, restart_busy_o;
   int          n_fail, cmp_count, cyc, n;

   accel_config_status_regs #(.LATCH_TICK_CYC(4)) dut_u (.*);
   accel_host_model host_u (.core_clk_i, .waitrequest_i(waitrequest_o),
      .readdata_i(readdata_o), .address_o(address_i), .read_o(read_i),
      .write_o(write_i), .writedata_o(writedata_i),
      .byteenable_o(byteenable_i));

   task automatic ck(input logic [7:0] e, g);
      cmp_count++;
      if (g !== e) begin
         n_fail++;
         $display("CHECK FAILED t=%0t exp=%h got=%h", $time, e, g);
      end
   endtask : ck
   task automatic wr(input logic [7:0] a, d);
      host_u.xfer(1'b1, a, d, 4'hf, q);
   endtask : wr
   task automatic rc(input logic [7:0] a, e);
      host_u.xfer(1'b0, a, 8'h00, 4'hf, q);
      ck(e, q);
   endtask : rc
   task automatic hit(input logic s, input logic [2:0] ax);
      high_sign_i <= s;
      high_axis_i <= ax;
      high_trig_i <= 1'b1;
      @(posedge core_clk_i);
      high_trig_i <= 1'b0;
   endtask : hit

   // ----
   // scenarios
   // ----
   task automatic t_cfg;
      logic [7:0] rg[4] = '{8'h03, 8'h05, 8'h08, 8'h0c};
      logic [7:0] bw[4] = '{8'h08, 8'h0e, 8'h0f, 8'h1f};
      rc(8'h3c, 8'h03);
      rc(8'h40, 8'h0f);
      rc(8'h58, 8'h00);
      rc(8'h5c, 8'h00);
      rc(8'h64, 8'h00);
      foreach (rg[i]) begin
         wr(8'h3c, rg[i]);
         rc(8'h3c, rg[i]);
         ck(rg[i], {4'h0, range_o});
         wr(8'h40, bw[i]);
         rc(8'h40, bw[i]);
         ck({7'h0, bw[i] >= 8'h0f}, {7'h0, top_output_rate_o});
      end
      wr(8'h3c, 8'hf5);
      host_u.xfer(1'b1, 8'h3c, 8'h08, 4'h0, q);
      rc(8'h3c, 8'h05);
      wr(8'h50, 8'h12);
      rc(8'h50, 8'h00);
      ck(8'h00, {7'h0, restart_busy_o});
      wr(8'h58, 8'hff);
      rc(8'h58, 8'hf7);
      wr(8'h5c, 8'hff);
      rc(8'h5c, 8'h1f);
      ck(8'h1f, {3'h0, event_enable_b_o});
   endtask : t_cfg
   task automatic t_power;
      logic [2:0] md[4] = '{3'h0, 3'h1, 3'h2, 3'h4};
      logic [3:0] dz[4] = '{4'h0, 4'h5, 4'h6, 4'hf};
      foreach (md[i]) begin
         wr(8'h44, {md[i], dz[i], 1'b1});
         rc(8'h44, {md[i], dz[i], 1'b0});
         ck({5'h0, md[i]}, {5'h0, power_mode_o});
         ck({4'h0, dz[i]}, {4'h0, doze_len_o});
      end
      wr(8'h48, 8'hff);
      rc(8'h48, 8'h40);
      ck(8'h01, {7'h0, power_variant_o});
      wr(8'h48, 8'h00);
   endtask : t_power
   task automatic t_flags;
      wr(8'h58, 8'h00);
      level_pos_i <= 1'b1;
      pose_i <= 3'b101;
      rc(8'h30, 8'h00);
      wr(8'h58, 8'hc0);
      rc(8'h30, 8'hd0);
      pose_block_i <= 1'b1;
      pose_i <= 3'b010;
      rc(8'h30, 8'hd0);
      pose_block_i <= 1'b0;
      level_pos_i <= 1'b0;
      wr(8'h84, 8'h07);
      wr(8'h5c, 8'h07);
      rc(8'h30, 8'h20);
      hit(1'b1, 3'b010);
      rc(8'h30, 8'h2a);
      wr(8'h84, 8'h87);
      rc(8'h30, 8'h20);
      hit(1'b0, 3'b001);
      rc(8'h30, 8'h21);
      wr(8'h84, 8'h00);
      hit(1'b1, 3'b100);
      rc(8'h30, 8'h20);
      wr(8'h84, 8'h0a);
      hit(1'b0, 3'b100);
      rc(8'h30, 8'h24);
      repeat (8) @(posedge core_clk_i);
      rc(8'h30, 8'h20);
   endtask : t_flags
   task automatic t_readout;
      acc_filt_i <= {28'h0, 14'h2abc};
      acc_raw_i <= {28'h0, 14'h1357};
      rc(8'h08, 8'hf0);
      acc_filt_i <= 42'h0;
      rc(8'h0c, 8'haa);
      rc(8'h0c, 8'h00);
      wr(8'h4c, 8'hc0);
      rc(8'h08, 8'h5c);
      acc_raw_i <= 42'h0;
      rc(8'h0c, 8'h00);
   endtask : t_readout
   task automatic t_restart;
      wr(8'h44, 8'h40);
      wr(8'h50, 8'hb6);
      @(negedge core_clk_i);
      ck(8'h01, {7'h0, restart_busy_o});
      n = 0;
      while (restart_busy_o !== 1'b0 && n < 100) begin
         @(negedge core_clk_i);
         n++;
      end
      ck(8'h01, {7'h0, n > 36 && n < 42});
      rc(8'h3c, 8'h03);
      rc(8'h44, 8'h00);
      rc(8'h4c, 8'h00);
      rc(8'h58, 8'h00);
      wr(8'h3c, 8'h0c);
      rc(8'h3c, 8'h0c);
   endtask : t_restart

   task automatic end_of_test;
      $display("comparisons %0d mismatches %0d", cmp_count, n_fail);
      if (n_fail == 0 && cmp_count > 0)
         $display("Run complete: PASS");
      else
         $display("Run complete: FAIL");
      $finish;
   endtask : end_of_test

   initial begin
      core_clk_i = 1'b0;
      forever #12.5 core_clk_i = ~core_clk_i;
   end
   initial begin
      reset_n_i = 1'b0;
      {level_pos_i, pose_block_i, high_trig_i, high_sign_i} = 4'h0;
      {pose_i, high_axis_i} = 6'h00;
      acc_filt_i = 42'h0;
      acc_raw_i = 42'h0;
      repeat (3) @(posedge core_clk_i);
      reset_n_i <= 1'b1;
      t_cfg;
      t_power;
      t_flags;
      t_readout;
      t_restart;
      end_of_test;
   end
   always @(posedge core_clk_i) begin
      cyc <= cyc + 1;
      if (cyc == 4000) begin
         n_fail++;
         end_of_test;
      end
   end
endmodule : accel_config_status_regs_test

// file: bench/accel_host_model.sv
// host model issuing register port transfers
module accel_host_model (
   // clock and answer
   input  wire logic        core_clk_i,
   input  wire logic        waitrequest_i,
   input  wire logic [31:0] readdata_i,
   // request
   output logic [7:0]       address_o,
   output logic             read_o,
   output logic             write_o,
   output logic [31:0]      writedata_o,
   output logic [3:0]       byteenable_o
);
   timeunit 1ns;
   timeprecision 1ps;
   initial begin
      address_o = 8'h00;
      read_o = 1'b0;
      write_o = 1'b0;
      writedata_o = 32'h0;
      byteenable_o = 4'h0;
   end
   // request held until waitrequest seen low, then released
   task automatic xfer(input logic wr, input logic [7:0] a, d,
                       input logic [3:0] be, output logic [7:0] q);
      @(posedge core_clk_i);
      address_o <= a;
      read_o <= ~wr;
      write_o <= wr;
      writedata_o <= {24'h0, d};
      byteenable_o <= be;
      do @(posedge core_clk_i); while (waitrequest_i !== 1'b0);
      q = readdata_i[7:0];
      read_o <= 1'b0;
      write_o <= 1'b0;
      address_o <= ~a;
      writedata_o <= ~{24'h0, d};
   endtask : xfer
endmodule : accel_host_model

// file: verilog/accel_config_status_regs.sv
// configuration and event status register bank of the sensor
//
// Function
// - event flags set on detection; latch-mode field picks latching, pose excepted
// - status bit 7 is 1 when level, valid only with level enable
// - pose code: bit 2 z facing, bits 1:0 in-plane pose
// - pose code tracks present pose, holds while pose blocked
// - high-acceleration sign bit: 0 positive, 1 negative trigger
// - per-axis bits tell which axis caused high acceleration
// - four-bit range field, reset 0011, reserved codes written like any other
// - five-bit bandwidth field, reset 01111, 01111 and 1xxxx top rate
// - halt, economy and deep-halt bits select main power mode
// - economy-variant bit chooses between paired power modes
// - four-bit doze-length field sets low power sleep phase
// - raw-readout select: 0 filtered data, 1 unfiltered data
// - lock on: low byte read freezes high byte until read
// - writing b6 to restart register resets settings after delay
// - first enable register: level, pose, knocks, per-axis slope
// - second enable register: new data, low, per-axis high
// - flags only produced when their function is enabled
// - latch-mode field: none, latched, or timed 250 us to 8 s
module accel_config_status_regs #(
   parameter int LATCH_TICK_CYC = accel_regs_pkg::LATCH_TICK_CYC
) (
   // clock and reset
   input  wire logic        core_clk_i,
   input  wire logic        reset_n_i,
   // avalon-mm slave
   input  wire logic [7:0]  address_i,
   input  wire logic        read_i,
   input  wire logic        write_i,
   input  wire logic [31:0] writedata_i,
   input  wire logic [3:0]  byteenable_i,
   output logic [31:0]      readdata_o,
   output logic             waitrequest_o,
   // detection engines
   input  wire logic        level_pos_i,
   input  wire logic [2:0]  pose_i,
   input  wire logic        pose_block_i,
   input  wire logic        high_trig_i,
   input  wire logic        high_sign_i,
   input  wire logic [2:0]  high_axis_i,
   // sensing path
   input  wire logic [41:0] acc_filt_i,
   input  wire logic [41:0] acc_raw_i,
   // settings to the sensor
   output logic [3:0]       range_o,
   output logic [4:0]       filter_width_code_o,
   output logic             top_output_rate_o,
   output logic [2:0]       power_mode_o,
   output logic             power_variant_o,
   output logic [3:0]       doze_len_o,
   output logic [7:0]       event_enable_a_o,
   output logic [4:0]       event_enable_b_o,
   output logic             restart_busy_o
);

   // -------------------------------------------------------------------
   // bus handshake
   // -------------------------------------------------------------------
   logic        wait_ff;
   logic [31:0] rdata_ff;
   logic        req;
   logic        commit;
   logic        wr_go;
   logic        rd_go;
   logic [5:0]  idx;
   logic [7:0]  wbyte;
   logic [7:0]  rbyte;

   assign req    = read_i | write_i;
   assign commit = req & ~wait_ff;
   assign wr_go  = commit & write_i & byteenable_i[0];
   assign rd_go  = commit & read_i;
   assign idx    = address_i[7:2];
   assign wbyte  = writedata_i[7:0];

   // one wait cycle, then the answer stands for a single cycle
   always_ff @(posedge core_clk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         wait_ff <= 1'b1;
      end else begin
         wait_ff <= ~(req & wait_ff);
      end
   end

   always_ff @(posedge core_clk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         rdata_ff <= 32'h0000_0000;
      end else if (req && wait_ff) begin
         rdata_ff <= read_i ? {24'h00_0000, rbyte} : 32'h0000_0000;
      end
   end

   assign waitrequest_o = wait_ff;
   assign readdata_o    = rdata_ff;

   // -------------------------------------------------------------------
   // software restart
   // -------------------------------------------------------------------
   localparam int RC_W = $clog2(accel_regs_pkg::RESTART_DELAY_CYC + 1);
   localparam logic [RC_W-1:0] RC_LOAD =
      RC_W'(accel_regs_pkg::RESTART_DELAY_CYC);

   logic            busy_ff;
   logic [RC_W-1:0] rcnt_ff;
   logic            restart;

   assign restart = busy_ff && (rcnt_ff == '0);

   always_ff @(posedge core_clk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         busy_ff <= 1'b0;
         rcnt_ff <= '0;
      end else if (wr_go && idx == accel_regs_pkg::IDX_RESTART &&
                   wbyte == accel_regs_pkg::RESTART_CODE) begin
         busy_ff <= 1'b1;
         rcnt_ff <= RC_LOAD;
      end else if (restart) begin
         busy_ff <= 1'b0;
      end else if (busy_ff) begin
         rcnt_ff <= rcnt_ff - 1'b1;
      end
   end

   assign restart_busy_o = busy_ff;

   // -------------------------------------------------------------------
   // configuration registers
   // -------------------------------------------------------------------
   logic [7:0] range_ff;
   logic [7:0] bw_ff;
   logic [7:0] doze_ff;
   logic [7:0] variant_ff;
   logic [7:0] readout_ff;
   logic [7:0] en_a_ff;
   logic [7:0] en_b_ff;
   logic [7:0] latch_ff;

   always_ff @(posedge core_clk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         range_ff   <= accel_regs_pkg::RANGE_RST;
         bw_ff      <= accel_regs_pkg::BW_RST;
         doze_ff    <= accel_regs_pkg::CFG_RST;
         variant_ff <= accel_regs_pkg::CFG_RST;
         readout_ff <= accel_regs_pkg::CFG_RST;
         en_a_ff    <= accel_regs_pkg::CFG_RST;
         en_b_ff    <= accel_regs_pkg::CFG_RST;
         latch_ff   <= accel_regs_pkg::CFG_RST;
      end else if (restart) begin
         range_ff   <= accel_regs_pkg::RANGE_RST;
         bw_ff      <= accel_regs_pkg::BW_RST;
         doze_ff    <= accel_regs_pkg::CFG_RST;
         variant_ff <= accel_regs_pkg::CFG_RST;
         readout_ff <= accel_regs_pkg::CFG_RST;
         en_a_ff    <= accel_regs_pkg::CFG_RST;
         en_b_ff    <= accel_regs_pkg::CFG_RST;
         latch_ff   <= accel_regs_pkg::CFG_RST;
      end else if (wr_go) begin
         case (idx)
            accel_regs_pkg::IDX_FULL_SCALE:
               range_ff <= wbyte & accel_regs_pkg::RANGE_MASK;
            accel_regs_pkg::IDX_FILTER_W:
               bw_ff <= wbyte & accel_regs_pkg::BW_MASK;
            accel_regs_pkg::IDX_PWR_DOZE:
               doze_ff <= wbyte & accel_regs_pkg::DOZE_MASK;
            accel_regs_pkg::IDX_PWR_VARIANT:
               variant_ff <= wbyte & accel_regs_pkg::VARIANT_MASK;
            accel_regs_pkg::IDX_READOUT:
               readout_ff <= wbyte & accel_regs_pkg::READOUT_MASK;
            accel_regs_pkg::IDX_EN_A:
               en_a_ff <= wbyte & accel_regs_pkg::EN_A_MASK;
            accel_regs_pkg::IDX_EN_B:
               en_b_ff <= wbyte & accel_regs_pkg::EN_B_MASK;
            accel_regs_pkg::IDX_LATCH_CTRL:
               latch_ff <= wbyte & accel_regs_pkg::LATCH_MASK;
            default: begin
            end
         endcase
      end
   end

   // settings driven straight from the registers
   assign range_o             = range_ff[3:0];
   assign filter_width_code_o = bw_ff[4:0];
   assign power_mode_o        = doze_ff[7:5];
   assign power_variant_o     =
      variant_ff[accel_regs_pkg::VARIANT_BIT];
   assign doze_len_o          = doze_ff[4:1];
   assign event_enable_a_o    = en_a_ff;
   assign event_enable_b_o    = en_b_ff[4:0];

   logic top_rate_ff;

   always_ff @(posedge core_clk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         top_rate_ff <= 1'b1;
      end else begin
         top_rate_ff <=
            (bw_ff[4:0] >= accel_regs_pkg::BW_TOP_RATE);
      end
   end

   assign top_output_rate_o = top_rate_ff;

   // -------------------------------------------------------------------
   // latch period tick
   // -------------------------------------------------------------------
   localparam int TK_W = $clog2(LATCH_TICK_CYC + 1);
   localparam logic [TK_W-1:0] TK_LAST = TK_W'(LATCH_TICK_CYC - 1);

   logic [TK_W-1:0] tick_cnt_ff;
   logic            tick_ff;

   always_ff @(posedge core_clk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         tick_cnt_ff <= '0;
         tick_ff     <= 1'b0;
      end else if (tick_cnt_ff == TK_LAST) begin
         tick_cnt_ff <= '0;
         tick_ff     <= 1'b1;
      end else begin
         tick_cnt_ff <= tick_cnt_ff + 1'b1;
         tick_ff     <= 1'b0;
      end
   end

   // -------------------------------------------------------------------
   // event flags: 0 level position, 1 high acceleration
   // -------------------------------------------------------------------
   logic       high_hit;
   logic [1:0] ev_active;
   logic [1:0] ev_flag;
   logic       clr_cmd;
   logic       no_latch;
   logic       keep_latch;

   assign high_hit = high_trig_i && ((high_axis_i & en_b_ff[2:0]) != 3'h0);
   assign ev_active[0] =
      level_pos_i & en_a_ff[accel_regs_pkg::EN_A_LEVEL_BIT];
   assign ev_active[1] = high_hit;
   assign clr_cmd    = wr_go && idx == accel_regs_pkg::IDX_LATCH_CTRL &&
                       wbyte[accel_regs_pkg::LATCH_CLR_BIT];
   assign no_latch   = latch_ff[2:0] == accel_regs_pkg::LATCH_NONE;
   assign keep_latch = latch_ff[2:0] == accel_regs_pkg::LATCH_KEEP;

   for (genvar e = 0; e < 2; e++) begin : g_event
      accel_regs_pkg::latch_ticks_t tmr_ff;
      logic                         flag_ff;

      assign ev_flag[e] = flag_ff;
      // a new hit wins over the clear and restarts the hold time
      always_ff @(posedge core_clk_i or negedge reset_n_i) begin
         if (!reset_n_i) begin
            flag_ff <= 1'b0;
            tmr_ff  <= '0;
         end else if (ev_active[e]) begin
            flag_ff <= 1'b1;
            tmr_ff <= accel_regs_pkg::latch_ticks(latch_ff[3:0]);
         end else if (no_latch || clr_cmd || restart) begin
            flag_ff <= 1'b0;
         end else if (!keep_latch && flag_ff && tick_ff) begin
            if (tmr_ff <= 15'h0001) begin
               flag_ff <= 1'b0;
            end else begin
               tmr_ff <= tmr_ff - 15'h0001;
            end
         end
      end
   end

   // -------------------------------------------------------------------
   // event details
   // -------------------------------------------------------------------
   logic       high_sign_ff;
   logic [2:0] high_axis_ff;
   logic [2:0] pose_ff;

   always_ff @(posedge core_clk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         high_sign_ff <= 1'b0;
         high_axis_ff <= 3'h0;
      end else if (high_hit) begin
         high_sign_ff <= high_sign_i;
         high_axis_ff <= high_axis_i & en_b_ff[2:0];
      end
   end

   // pose follows live state, never latched
   always_ff @(posedge core_clk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         pose_ff <= 3'h0;
      end else if (en_a_ff[accel_regs_pkg::EN_A_POSE_BIT] &&
                   !pose_block_i) begin
         pose_ff <= pose_i;
      end
   end

   logic [7:0] detail;

   assign detail = {ev_flag[0], pose_ff,
                    ev_flag[1] ? {high_sign_ff, high_axis_ff}
                                  : 4'h0};

   // -------------------------------------------------------------------
   // acceleration readout
   // -------------------------------------------------------------------
   axis_readout_if axis_rd [3] ();
   logic [7:0] acc_lo [3];
   logic [7:0] acc_hi [3];

   for (genvar a = 0; a < 3; a++) begin : g_axis
      localparam logic [5:0] LO_IDX = accel_regs_pkg::IDX_ACC_X_LO +
                                      6'(2 * a);

      assign axis_rd[a].sample =
         readout_ff[accel_regs_pkg::RAW_SEL_BIT]
            ? acc_raw_i[14*a +: 14] : acc_filt_i[14*a +: 14];
      assign axis_rd[a].lo_read = rd_go && idx == LO_IDX;
      assign axis_rd[a].hi_read = rd_go && idx == LO_IDX + 6'h01;
      assign axis_rd[a].lock_en =
         ~readout_ff[accel_regs_pkg::SHADOW_DIS_BIT];
      assign acc_lo[a] = axis_rd[a].lo_byte;
      assign acc_hi[a] = axis_rd[a].hi_byte;

      axis_readout_lock u_lock (
         .core_clk_i (core_clk_i),
         .reset_n_i  (reset_n_i),
         .rd         (axis_rd[a])
      );
   end

   // -------------------------------------------------------------------
   // read mux
   // -------------------------------------------------------------------
   always_comb begin
      case (idx)
         accel_regs_pkg::IDX_ACC_X_LO:    rbyte = acc_lo[0];
         accel_regs_pkg::IDX_ACC_X_HI:    rbyte = acc_hi[0];
         accel_regs_pkg::IDX_ACC_Y_LO:    rbyte = acc_lo[1];
         accel_regs_pkg::IDX_ACC_Y_HI:    rbyte = acc_hi[1];
         accel_regs_pkg::IDX_ACC_Z_LO:    rbyte = acc_lo[2];
         accel_regs_pkg::IDX_ACC_Z_HI:    rbyte = acc_hi[2];
         accel_regs_pkg::IDX_EVT_DETAIL:  rbyte = detail;
         accel_regs_pkg::IDX_FULL_SCALE:  rbyte = range_ff;
         accel_regs_pkg::IDX_FILTER_W:    rbyte = bw_ff;
         accel_regs_pkg::IDX_PWR_DOZE:    rbyte = doze_ff;
         accel_regs_pkg::IDX_PWR_VARIANT: rbyte = variant_ff;
         accel_regs_pkg::IDX_READOUT:     rbyte = readout_ff;
         accel_regs_pkg::IDX_EN_A:        rbyte = en_a_ff;
         accel_regs_pkg::IDX_EN_B:        rbyte = en_b_ff;
         accel_regs_pkg::IDX_LATCH_CTRL:  rbyte = latch_ff;
         default:                         rbyte = 8'h00;
      endcase
   end

endmodule : accel_config_status_regs

// file: verilog/accel_regs_pkg.sv
// constants, offsets and field layout of the sensor register bank
package accel_regs_pkg;

   // -------------------------------------------------------------------
   // register indices (byte address is four times the index)
   // -------------------------------------------------------------------
   localparam logic [5:0] IDX_ACC_X_LO    = 6'h02;
   localparam logic [5:0] IDX_ACC_X_HI    = 6'h03;
   localparam logic [5:0] IDX_ACC_Y_LO    = 6'h04;
   localparam logic [5:0] IDX_ACC_Y_HI    = 6'h05;
   localparam logic [5:0] IDX_ACC_Z_LO    = 6'h06;
   localparam logic [5:0] IDX_ACC_Z_HI    = 6'h07;
   localparam logic [5:0] IDX_EVT_DETAIL  = 6'h0c;
   localparam logic [5:0] IDX_FULL_SCALE  = 6'h0f;
   localparam logic [5:0] IDX_FILTER_W    = 6'h10;
   localparam logic [5:0] IDX_PWR_DOZE    = 6'h11;
   localparam logic [5:0] IDX_PWR_VARIANT = 6'h12;
   localparam logic [5:0] IDX_READOUT     = 6'h13;
   localparam logic [5:0] IDX_RESTART     = 6'h14;
   localparam logic [5:0] IDX_EN_A        = 6'h16;
   localparam logic [5:0] IDX_EN_B        = 6'h17;
   localparam logic [5:0] IDX_LATCH_CTRL  = 6'h21;

   // -------------------------------------------------------------------
   // field layout, masks and reset values
   // -------------------------------------------------------------------
   localparam logic [7:0] RANGE_RST       = 8'h03;
   localparam logic [7:0] RANGE_MASK      = 8'h0f;
   localparam logic [7:0] BW_RST          = 8'h0f;
   localparam logic [7:0] BW_MASK         = 8'h1f;
   localparam logic [4:0] BW_TOP_RATE     = 5'h0f;
   localparam logic [7:0] DOZE_MASK       = 8'hfe;
   localparam logic [7:0] VARIANT_MASK    = 8'h40;
   localparam logic [7:0] READOUT_MASK    = 8'hc0;
   localparam logic [7:0] EN_A_MASK       = 8'hf7;
   localparam logic [7:0] EN_B_MASK       = 8'h1f;
   localparam logic [7:0] LATCH_MASK      = 8'h0f;
   localparam logic [7:0] CFG_RST         = 8'h00;
   localparam logic [7:0] RESTART_CODE    = 8'hb6;
   localparam int         EN_A_LEVEL_BIT  = 7;
   localparam int         EN_A_POSE_BIT   = 6;
   localparam int         RAW_SEL_BIT     = 7;
   localparam int         SHADOW_DIS_BIT  = 6;
   localparam int         VARIANT_BIT     = 6;
   localparam int         LATCH_CLR_BIT   = 7;
   localparam logic [2:0] LATCH_NONE      = 3'h0;
   localparam logic [2:0] LATCH_KEEP      = 3'h7;

   // -------------------------------------------------------------------
   // timing
   // -------------------------------------------------------------------
   localparam int CLK_PERIOD_NS     = 25;
   localparam int LATCH_TICK_NS     = 250000;
   localparam int LATCH_TICK_CYC    = LATCH_TICK_NS / CLK_PERIOD_NS;
   localparam int RESTART_DELAY_NS  = 1000;
   localparam int RESTART_DELAY_CYC = RESTART_DELAY_NS / CLK_PERIOD_NS;
   localparam int LT_US_A1 = 250;
   localparam int LT_US_A2 = 500;
   localparam int LT_US_A3 = 1000;
   localparam int LT_US_A4 = 12500;
   localparam int LT_US_A5 = 25000;
   localparam int LT_US_A6 = 50000;
   localparam int LT_US_B1 = 250000;
   localparam int LT_US_B2 = 500000;
   localparam int LT_US_B3 = 1000000;
   localparam int LT_US_B4 = 2000000;
   localparam int LT_US_B5 = 4000000;
   localparam int LT_US_B6 = 8000000;
   localparam int LATCH_TICK_US = LATCH_TICK_NS / 1000;

   typedef logic [14:0] latch_ticks_t;

   // hold time of temporary latching, in 250 us ticks
   function automatic latch_ticks_t latch_ticks(input logic [3:0] code);
      int us;
      case (code)
         4'h9:    us = LT_US_A1;
         4'ha:    us = LT_US_A2;
         4'hb:    us = LT_US_A3;
         4'hc:    us = LT_US_A4;
         4'hd:    us = LT_US_A5;
         4'he:    us = LT_US_A6;
         4'h1:    us = LT_US_B1;
         4'h2:    us = LT_US_B2;
         4'h3:    us = LT_US_B3;
         4'h4:    us = LT_US_B4;
         4'h5:    us = LT_US_B5;
         4'h6:    us = LT_US_B6;
         default: us = LT_US_A1;
      endcase
      return latch_ticks_t'(us / LATCH_TICK_US);
   endfunction : latch_ticks

endpackage : accel_regs_pkg

// file: verilog/axis_readout_if.sv
// signals between the register bank and one axis readout lock
interface axis_readout_if;
   logic [13:0] sample;
   logic        lo_read;
   logic        hi_read;
   logic        lock_en;
   logic [7:0]  lo_byte;
   logic [7:0]  hi_byte;

   modport bank (output sample, lo_read, hi_read, lock_en,
                 input lo_byte, hi_byte);
   modport lock (input sample, lo_read, hi_read, lock_en,
                 output lo_byte, hi_byte);
endinterface : axis_readout_if

// file: verilog/axis_readout_lock.sv
// one axis readout with high byte frozen between low and high reads
module axis_readout_lock (
   // clock and reset
   input  wire logic       core_clk_i,
   input  wire logic       reset_n_i,
   // bank side
   axis_readout_if.lock    rd
);

   logic       hold_ff;
   logic [7:0] hi_ff;

   // -------------------------------------------------------------------
   // freeze
   // -------------------------------------------------------------------
   always_ff @(posedge core_clk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         hold_ff <= 1'b0;
      end else if (rd.hi_read) begin
         hold_ff <= 1'b0;
      end else if (rd.lo_read && rd.lock_en) begin
         hold_ff <= 1'b1;
      end
   end

   always_ff @(posedge core_clk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         hi_ff <= 8'h00;
      end else if (rd.lo_read && rd.lock_en) begin
         hi_ff <= rd.sample[13:6];
      end
   end

   assign rd.lo_byte = {rd.sample[5:0], 2'h0};
   assign rd.hi_byte = hold_ff ? hi_ff : rd.sample[13:6];

endmodule : axis_readout_lock
